// [design/tx_interp_pkg.sv]
// Shared constants and types for the transmit interpolation and gain path
package tx_interp_pkg;
   // ***************************************************
   // Register offsets
   // ***************************************************
   localparam logic [7:0] ADDR_TX_GAIN = 8'h0a;
   localparam logic [7:0] ADDR_GAIN_SOURCE = 8'h0b;
   localparam logic [7:0] ADDR_INTERP = 8'h0c;
   localparam logic [7:0] ADDR_ROUTE = 8'h0e;
   localparam logic [7:0] ADDR_MIRROR_A = 8'h10;
   localparam logic [7:0] ADDR_MIRROR_B = 8'h11;
   localparam logic [7:0] ADDR_OFFSET = 8'h12;

   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0] RST_TX_GAIN = 8'h00;
   localparam logic [7:0] RST_GAIN_SOURCE = 8'h00;
   localparam logic [7:0] RST_INTERP = 8'h00;
   localparam logic [7:0] RST_ROUTE = 8'h00;
   localparam logic [7:0] RST_MIRROR_A = 8'h44;
   localparam logic [7:0] RST_MIRROR_B = 8'h43;
   localparam logic [7:0] RST_OFFSET = 8'h00;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int INTERP_LSB = 6;
   localparam int ROUTE_DAC_ONLY_BIT = 0;
   localparam int MIRROR_ENABLE_BIT = 7;
   localparam int PRIMARY_LSB = 0;
   localparam int SEC_ONE_LSB = 4;
   localparam int SEC_TWO_LSB = 4;
   localparam int SEC_THREE_LSB = 0;
   localparam int OFFSET_SEC_LSB = 4;
   localparam int OFFSET_PRI_LSB = 0;
   localparam int TX_GAIN_UPDATE_BIT = 6;
   localparam int GAIN_PORT_SELECT_BIT = 6;
   localparam int FIELD_W = 3;
   localparam int GAIN_W = 6;

   // ***************************************************
   // Attenuator steps, in half-dB units
   // ***************************************************
   localparam logic [5:0] AMP_STEP_HALF_DB = 6'h0c;
   localparam logic [5:0] DAC_MAX_HALF_DB = 6'h0f;

   // ***************************************************
   // Rates and latency
   // ***************************************************
   localparam int CLOCK_MHZ = 200;
   localparam int MAX_INPUT_MSPS = 80;
   localparam int MAX_UPDATE_MSPS = 200;
   localparam int LATENCY_TWO_HALF_INPUT = 43;
   localparam int LATENCY_FOUR_INPUT = 24;
   localparam int LATENCY_TWO_UPDATE = LATENCY_TWO_HALF_INPUT;
   localparam int LATENCY_FOUR_UPDATE = LATENCY_FOUR_INPUT * 4;
   localparam int NATURAL_TWO_UPDATE = 23;
   localparam int NATURAL_FOUR_UPDATE = 48;
   localparam int PAD_TWO = LATENCY_TWO_UPDATE - NATURAL_TWO_UPDATE;
   localparam int PAD_FOUR = LATENCY_FOUR_UPDATE - NATURAL_FOUR_UPDATE;

   // ***************************************************
   // Half-band filters
   // ***************************************************
   localparam int S1_TAPS = 43;
   localparam int S2_TAPS = 11;
   localparam int S1_SIDE = (S1_TAPS + 1) / 4;
   localparam int S2_SIDE = (S2_TAPS + 1) / 4;
   localparam int COEF_W = 16;
   localparam int COEF_SHIFT = 15;
   localparam logic signed [COEF_W-1:0] S1_COEF [S1_SIDE] = '{
      16'sd20800, -16'sd6900, 16'sd4000, -16'sd2700, 16'sd1900, -16'sd1400,
      16'sd1000, -16'sd700, 16'sd450, -16'sd260, 16'sd120};
   localparam logic signed [COEF_W-1:0] S2_COEF [S2_SIDE] = '{
      16'sd20000, -16'sd4000, 16'sd400};

   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [1:0] {
      FACTOR_FOUR = 2'b00,
      FACTOR_TWO = 2'b01,
      FACTOR_ONE = 2'b10,
      FACTOR_RESERVED = 2'b11
   } interp_code_type;

   typedef struct packed {
      logic [1:0] amp_steps;
      logic [3:0] dac_steps;
   } tx_atten_type;

   typedef struct packed {
      logic [2:0] primary;
      logic [2:0] sec_one;
      logic [2:0] sec_two;
      logic [2:0] sec_three;
   } mirror_gain_type;
endpackage

// [design/sample_fifo.sv]
// Sample FIFO with valid and ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   logic full;
   logic empty;

   wire push = in_valid_in & ~full;
   wire pop = out_ready_in & ~empty;
   wire [CNT_W-1:0] next_count = count + CNT_W'(push) - CNT_W'(pop);

   assign in_ready_out = ~full;
   assign out_valid_out = ~empty;
   assign out_data_out = mem[rd_ptr];

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   // Full and empty are registered so the ready seen outside is glitch free
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         full <= 1'b0;
         empty <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + PTR_W'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + PTR_W'(1);
         end
         count <= next_count;
         full <= (next_count == FULL_COUNT);
         empty <= (next_count == '0);
      end
   end
endmodule

// [design/tx_interp_gain_path.sv]
// Transmit interpolator, attenuator split and mirror gain configuration
// Function
// R1 - Config bits 7:6 pick four, two, bypass
// R2 - Feeder keeps input within converter limits
// R3 - Feeder picks fourfold up to 50 MSPS
// R4 - Two cascaded half-band stages, 43 and 11
// R5 - Latency 21.5 or 24 input cycles
// R6 - Power down after last sample drains
// R7 - Attenuation from gain port or serial
// R8 - Converter half-dB steps, amplifier 6 dB steps
// R9 - Amplifier mapping valid only at 0x44
// R10 - Route bit clear feeds current amplifier
// R11 - Primary mirror gain 0 to 4
// R12 - Mirror fields apply only with enable
// R13 - Secondary gain from three stage fields
// R14 - Secondary stage field widths and steps
// R15 - Offset current fields, zero disables
// R16 - Serial gain access needs bit 6
// R17 - Gain port feeds gain register directly
// R18 - Converter-only uses four gain LSBs
// R19 - One converter sample each update clock
// R20 - Signed input, flush on factor change
`timescale 1ns/100ps
module tx_interp_gain_path #(
   parameter int DATA_W = 10,
   parameter int FIFO_DEPTH = 8,
   parameter int PAD_MAX = 64
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [DATA_W-1:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   input wire logic [5:0] parallel_gain_port_in,
   input wire logic [7:0] reg_address_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic tx_enable_in,
   input wire logic half_duplex_pd_enable_in,
   input wire logic [7:0] pd_delay_in,
   output logic [DATA_W-1:0] tx_converter_data_out,
   output logic tx_converter_update_out,
   output logic tx_power_down_out,
   output logic current_amplifier_enable_out,
   output tx_interp_pkg::tx_atten_type tx_atten_out,
   output tx_interp_pkg::mirror_gain_type mirror_gain_out,
   output logic [8:0] secondary_gain_quarters_out,
   output logic gain_map_valid_out,
   output logic [2:0] primary_offset_current_out,
   output logic [2:0] secondary_offset_current_out
);
   localparam int L1 = 2 * tx_interp_pkg::S1_SIDE;
   localparam int L2 = 2 * tx_interp_pkg::S2_SIDE;
   localparam int ACC_W = 32;
   localparam int PAD_W = $clog2(PAD_MAX);
   localparam int FW = tx_interp_pkg::FIELD_W;

   // ***************************************************
   // Registers
   // ***************************************************
   logic [7:0] tx_gain;
   logic [7:0] gain_source;
   logic [7:0] interp_factor_config;
   logic [7:0] tx_output_route;
   logic [7:0] mirror_gain_primary_stage1;
   logic [7:0] mirror_gain_stage2_stage3;
   logic [7:0] offset_current_config;

   wire wr_tx_gain = reg_write_in & (reg_address_in == tx_interp_pkg::ADDR_TX_GAIN);
   wire wr_source = reg_write_in & (reg_address_in == tx_interp_pkg::ADDR_GAIN_SOURCE);
   wire wr_interp = reg_write_in & (reg_address_in == tx_interp_pkg::ADDR_INTERP);
   wire wr_route = reg_write_in & (reg_address_in == tx_interp_pkg::ADDR_ROUTE);
   wire wr_mirror_a = reg_write_in & (reg_address_in == tx_interp_pkg::ADDR_MIRROR_A);
   wire wr_mirror_b = reg_write_in & (reg_address_in == tx_interp_pkg::ADDR_MIRROR_B);
   wire wr_offset = reg_write_in & (reg_address_in == tx_interp_pkg::ADDR_OFFSET);
   wire gain_port_selected = gain_source[tx_interp_pkg::GAIN_PORT_SELECT_BIT];
   wire serial_gain_ok = reg_wdata_in[tx_interp_pkg::TX_GAIN_UPDATE_BIT]; // R16

   wire [7:0] read_value =
      (reg_address_in == tx_interp_pkg::ADDR_TX_GAIN) ? tx_gain :
      (reg_address_in == tx_interp_pkg::ADDR_GAIN_SOURCE) ? gain_source :
      (reg_address_in == tx_interp_pkg::ADDR_INTERP) ? interp_factor_config :
      (reg_address_in == tx_interp_pkg::ADDR_ROUTE) ? tx_output_route :
      (reg_address_in == tx_interp_pkg::ADDR_MIRROR_A) ? mirror_gain_primary_stage1 :
      (reg_address_in == tx_interp_pkg::ADDR_MIRROR_B) ? mirror_gain_stage2_stage3 :
      (reg_address_in == tx_interp_pkg::ADDR_OFFSET) ? offset_current_config : 8'h00;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_gain <= tx_interp_pkg::RST_TX_GAIN;
         gain_source <= tx_interp_pkg::RST_GAIN_SOURCE;
         interp_factor_config <= tx_interp_pkg::RST_INTERP;
         tx_output_route <= tx_interp_pkg::RST_ROUTE;
         mirror_gain_primary_stage1 <= tx_interp_pkg::RST_MIRROR_A;
         mirror_gain_stage2_stage3 <= tx_interp_pkg::RST_MIRROR_B;
         offset_current_config <= tx_interp_pkg::RST_OFFSET;
         reg_rdata_out <= 8'h00;
      end else begin
         if (gain_port_selected) begin
            tx_gain <= {2'b00, parallel_gain_port_in}; // R17 R7
         end else if (wr_tx_gain && serial_gain_ok) begin
            tx_gain <= {2'b00, reg_wdata_in[5:0]}; // R16 R7
         end
         if (wr_source) gain_source <= reg_wdata_in;
         if (wr_interp) interp_factor_config <= reg_wdata_in;
         if (wr_route) tx_output_route <= reg_wdata_in;
         if (wr_mirror_a) mirror_gain_primary_stage1 <= reg_wdata_in;
         if (wr_mirror_b) mirror_gain_stage2_stage3 <= reg_wdata_in;
         if (wr_offset) offset_current_config <= reg_wdata_in;
         if (reg_read_in) reg_rdata_out <= read_value;
      end
   end

   // ***************************************************
   // Gain and routing outputs
   // ***************************************************
   wire dac_only = tx_output_route[tx_interp_pkg::ROUTE_DAC_ONLY_BIT];
   wire mirror_enable = mirror_gain_primary_stage1[tx_interp_pkg::MIRROR_ENABLE_BIT];
   wire [7:0] mirror_a_eff = mirror_enable ? mirror_gain_primary_stage1 :
                             tx_interp_pkg::RST_MIRROR_A; // R12
   wire [7:0] mirror_b_eff = mirror_enable ? mirror_gain_stage2_stage3 :
                             tx_interp_pkg::RST_MIRROR_B; // R12
   wire [FW-1:0] primary = mirror_a_eff[tx_interp_pkg::PRIMARY_LSB +: FW]; // R11
   wire [FW-1:0] sec_one = mirror_a_eff[tx_interp_pkg::SEC_ONE_LSB +: FW]; // R13 R14
   wire [FW-1:0] sec_two = mirror_b_eff[tx_interp_pkg::SEC_TWO_LSB +: FW]; // R14
   wire [FW-1:0] sec_three = mirror_b_eff[tx_interp_pkg::SEC_THREE_LSB +: FW]; // R14
   // Stage two counts quarters, so the product is the overall gain times four
   wire [8:0] sec_quarters = 9'(sec_one) * 9'(sec_two) * 9'(sec_three); // R13

   // Converter-only output ignores the two upper gain bits
   wire [5:0] atten_code = dac_only ? {2'b00, tx_gain[3:0]} : tx_gain[5:0]; // R18
   wire [1:0] amp_steps = (atten_code > 6'(2 * tx_interp_pkg::AMP_STEP_HALF_DB +
                                           tx_interp_pkg::DAC_MAX_HALF_DB - 6'h0c)) ? 2'd2 :
                          (atten_code > tx_interp_pkg::DAC_MAX_HALF_DB) ? 2'd1 : 2'd0; // R8
   wire [5:0] amp_half_db = 6'(amp_steps) * tx_interp_pkg::AMP_STEP_HALF_DB;
   wire [5:0] dac_rest = atten_code - amp_half_db;
   wire [3:0] dac_steps = (dac_rest > tx_interp_pkg::DAC_MAX_HALF_DB) ? 4'hf : dac_rest[3:0];

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_atten_out <= '0;
         mirror_gain_out <= '0;
         secondary_gain_quarters_out <= '0;
         gain_map_valid_out <= 1'b0;
         current_amplifier_enable_out <= 1'b0;
         primary_offset_current_out <= '0;
         secondary_offset_current_out <= '0;
      end else begin
         tx_atten_out <= '{amp_steps: dac_only ? 2'd0 : amp_steps, dac_steps: dac_steps}; // R7 R8
         mirror_gain_out <= '{primary, sec_one, sec_two, sec_three}; // R11 R13
         secondary_gain_quarters_out <= sec_quarters; // R13
         gain_map_valid_out <= (mirror_gain_primary_stage1 == tx_interp_pkg::RST_MIRROR_A); // R9
         current_amplifier_enable_out <= ~dac_only; // R10
         primary_offset_current_out <= offset_current_config[tx_interp_pkg::OFFSET_PRI_LSB +: FW]; // R15
         secondary_offset_current_out <= offset_current_config[tx_interp_pkg::OFFSET_SEC_LSB +: FW]; // R15
      end
   end

   // ***************************************************
   // Input buffer and rate divider
   // ***************************************************
   wire [1:0] factor_code = interp_factor_config[tx_interp_pkg::INTERP_LSB +: 2];
   // Reserved code is held at fourfold so the converter never overruns
   wire four = (factor_code == tx_interp_pkg::FACTOR_FOUR) ||
               (factor_code == tx_interp_pkg::FACTOR_RESERVED); // R1
   wire two = (factor_code == tx_interp_pkg::FACTOR_TWO); // R1
   wire one = (factor_code == tx_interp_pkg::FACTOR_ONE); // R1

   logic [1:0] last_code;
   logic [1:0] phase;
   wire flush = (factor_code != last_code); // R20
   wire in_strobe = ~flush & (four ? (phase == 2'd3) : two ? phase[0] : 1'b1); // R19

   logic fifo_valid;
   logic [DATA_W-1:0] fifo_data;
   // Underrun feeds midscale zero rather than stalling the converter
   wire signed [DATA_W-1:0] new_word = fifo_valid ? fifo_data : '0; // R20

   sample_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) input_fifo (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .in_valid_in(tx_valid_in),
      .in_ready_out(tx_ready_out),
      .in_data_in(tx_data_in),
      .out_valid_out(fifo_valid),
      .out_ready_in(in_strobe),
      .out_data_out(fifo_data)
   );

   // ***************************************************
   // Half-band stages
   // ***************************************************
   function automatic logic signed [DATA_W-1:0] scale_sat(input logic signed [ACC_W-1:0] a);
      logic signed [ACC_W-1:0] s;
      logic signed [ACC_W-1:0] hi;
      logic signed [ACC_W-1:0] lo;
      s = a >>> tx_interp_pkg::COEF_SHIFT;
      hi = ACC_W'((1 <<< (DATA_W - 1)) - 1);
      lo = -ACC_W'(1 <<< (DATA_W - 1));
      if (s > hi) s = hi;
      if (s < lo) s = lo;
      return s[DATA_W-1:0];
   endfunction

   logic signed [DATA_W-1:0] d1 [L1];
   logic signed [DATA_W-1:0] d2 [L2];
   logic signed [DATA_W-1:0] s1_out;
   logic signed [DATA_W-1:0] s2_out;
   logic signed [ACC_W-1:0] acc1;
   logic signed [ACC_W-1:0] acc2;

   // Odd polyphase branch; even branch is the centre sample itself
   always_comb begin
      acc1 = '0;
      for (int k = 0; k < tx_interp_pkg::S1_SIDE; k++) begin
         acc1 = acc1 + ACC_W'(tx_interp_pkg::S1_COEF[k]) *
                (ACC_W'(d1[L1/2-1-k]) + ACC_W'(d1[L1/2+k])); // R4
      end
   end

   always_comb begin
      acc2 = '0;
      for (int k = 0; k < tx_interp_pkg::S2_SIDE; k++) begin
         acc2 = acc2 + ACC_W'(tx_interp_pkg::S2_COEF[k]) *
                (ACC_W'(d2[L2/2-1-k]) + ACC_W'(d2[L2/2+k])); // R4
      end
   end

   wire s1_shift = in_strobe & ~one;
   wire s1_load = ~flush & (four ? ~phase[0] : two);
   wire s1_odd = four ? (phase == 2'd2) : phase[0];
   wire s2_shift = ~flush & four & phase[0];

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         last_code <= tx_interp_pkg::FACTOR_FOUR;
         phase <= 2'd0;
      end else begin
         last_code <= factor_code;
         phase <= flush ? 2'd0 : phase + 2'd1;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         d1 <= '{default: '0};
         d2 <= '{default: '0};
         s1_out <= '0;
         s2_out <= '0;
      end else if (flush) begin
         d1 <= '{default: '0}; // R20
         d2 <= '{default: '0}; // R20
         s1_out <= '0;
         s2_out <= '0;
      end else begin
         if (s1_shift) begin
            d1 <= {new_word, d1[0:L1-2]}; // R4
         end
         if (s1_load) begin
            s1_out <= s1_odd ? scale_sat(acc1) : d1[L1/2-1]; // R4
         end
         if (s2_shift) begin
            d2 <= {s1_out, d2[0:L2-2]}; // R4
         end
         s2_out <= phase[0] ? d2[L2/2-1] : scale_sat(acc2); // R4 R19
      end
   end

   // ***************************************************
   // Latency alignment and converter output
   // ***************************************************
   logic signed [DATA_W-1:0] pad [PAD_MAX];
   wire signed [DATA_W-1:0] stage_out = four ? s2_out : s1_out;
   wire [PAD_W-1:0] pad_tap = four ? PAD_W'(tx_interp_pkg::PAD_FOUR - 1) :
                              PAD_W'(tx_interp_pkg::PAD_TWO - 1);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pad <= '{default: '0};
         tx_converter_data_out <= '0;
         tx_converter_update_out <= 1'b0;
      end else begin
         pad <= {stage_out, pad[0:PAD_MAX-2]};
         tx_converter_data_out <= one ? new_word : pad[pad_tap]; // R5 R19
         tx_converter_update_out <= ~flush; // R19
      end
   end

   // ***************************************************
   // Half-duplex power down
   // ***************************************************
   logic [7:0] pd_count;

   // Delay counts input-rate strobes, with or without a word, so the tail of the filter drains first
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pd_count <= 8'h00;
         tx_power_down_out <= 1'b0;
      end else if (tx_enable_in || !half_duplex_pd_enable_in) begin
         pd_count <= pd_delay_in;
         tx_power_down_out <= 1'b0;
      end else if (pd_count != 8'h00) begin
         if (in_strobe) pd_count <= pd_count - 8'h01; // R6
      end else begin
         tx_power_down_out <= 1'b1; // R6
      end
   end
endmodule

// [dv/tx_path_monitor.sv]
// Port checker for the transmit gain path
`timescale 1ns/100ps
module tx_path_monitor (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [7:0] reg_address_in,
   input wire logic reg_write_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic tx_enable_in,
   input wire logic tx_converter_update_out,
   input wire logic tx_power_down_out,
   input wire logic current_amplifier_enable_out,
   input wire tx_interp_pkg::tx_atten_type tx_atten_out,
   input wire tx_interp_pkg::mirror_gain_type mirror_gain_out,
   input wire logic [8:0] secondary_gain_quarters_out,
   input wire logic gain_map_valid_out,
   input wire logic [2:0] primary_offset_current_out,
   input wire logic [2:0] secondary_offset_current_out
);
   // ***************
   // Port relations
   // ***************
   wire cfg_wr = reg_write_in && reg_address_in == 8'h0c;
   wire mir_wr = reg_write_in && reg_address_in == 8'h10;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   a_route_amp:
      assert property (reg_write_in && reg_address_in == 8'h0e |=> ##1
         current_amplifier_enable_out == !$past(reg_wdata_in[0], 2)) else $error("amp enable");
   a_map_valid:
      assert property (mir_wr |-> ##2 gain_map_valid_out == ($past(reg_wdata_in, 2) == 8'h44))
         else $error("map valid");
   a_primary_gain:
      assert property (mir_wr |-> ##2 mirror_gain_out.primary ==
         ($past(reg_wdata_in[7], 2) ? $past(reg_wdata_in[2:0], 2) : 3'h4)) else $error("primary");
   a_offset_fields:
      assert property (reg_write_in && reg_address_in == 8'h12 |-> ##2
         {secondary_offset_current_out, primary_offset_current_out} ==
         {$past(reg_wdata_in[6:4], 2), $past(reg_wdata_in[2:0], 2)}) else $error("offset");
   a_quarter_product:
      assert property (secondary_gain_quarters_out == 9'(mirror_gain_out.sec_one) *
         mirror_gain_out.sec_two * mirror_gain_out.sec_three) else $error("quarters");
   a_converter_only:
      assert property (!current_amplifier_enable_out |-> tx_atten_out.amp_steps == 2'h0)
         else $error("amp steps");
   a_update_gap:
      assert property (!tx_converter_update_out && $past(resetn_in) |->
         $past(cfg_wr) || $past(cfg_wr, 2) || $past(cfg_wr, 3)) else $error("update gap");
   a_power_clear:
      assert property (tx_enable_in |=> !tx_power_down_out) else $error("power down");
endmodule
bind tx_interp_gain_path tx_path_monitor tx_path_monitor_i (.*);

// [dv/baseband_feeder.sv]
// Baseband model offering transmit words to the data port
`timescale 1ns/100ps
module baseband_feeder (
   input wire logic clk_in,
   input wire logic ready_in,
   output logic [9:0] data_out = 10'h000,
   output logic valid_out = 1'b0
);
   // ***************
   // Word handshake
   // ***************
   // Bursts lean on the FIFO to spread words out
   task automatic send(input logic [9:0] w);
      data_out = w;
      valid_out = 1'b1;
      @(posedge clk_in);
      while (!ready_in) @(posedge clk_in);
      #1;
   endtask
   // Released lines flip so a stale word never looks fresh
   task automatic idle();
      valid_out = 1'b0;
      data_out = ~data_out;
   endtask
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the transmit gain path
`timescale 1ns/100ps
module tb_top;
   logic clk_in = 1'b0, resetn_in = 1'b0, reg_write_in = 1'b0, reg_read_in = 1'b0;
   logic tx_enable_in = 1'b1, half_duplex_pd_enable_in = 1'b0, saw_full = 1'b0;
   logic [5:0] parallel_gain_port_in = 6'h00, c;
   logic [7:0] reg_address_in = 8'h00, reg_wdata_in = 8'h00, pd_delay_in = 8'h04, v;
   logic [7:0] reg_rdata_out;
   logic [9:0] tx_data_in, tx_converter_data_out, ps;
   logic [8:0] secondary_gain_quarters_out;
   logic [2:0] primary_offset_current_out, secondary_offset_current_out, p, s1, s2, s3;
   logic tx_valid_in, tx_ready_out, tx_converter_update_out, tx_power_down_out;
   logic current_amplifier_enable_out, gain_map_valid_out;
   tx_interp_pkg::tx_atten_type tx_atten_out;
   tx_interp_pkg::mirror_gain_type mirror_gain_out;
   logic [31:0] seed = 32'hf4b6;
   logic [7:0] ra [8] = '{8'h0a, 8'h0b, 8'h0c, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h05};
   logic [5:0] gc [7] = '{6'h00, 6'h0f, 6'h10, 6'h1b, 6'h1c, 6'h27, 6'h3f};
   int fail_count = 0, checked = 0, pk, pv, n;
   // ****************
   // Clock and tasks
   // ****************
   always #2.5 clk_in = ~clk_in;
   always @(posedge clk_in) if (resetn_in && !tx_ready_out) saw_full <= 1'b1;
   tx_interp_gain_path tx_interp_gain_path_i (.*);
   baseband_feeder baseband_feeder_i (.clk_in, .ready_in(tx_ready_out),
      .data_out(tx_data_in), .valid_out(tx_valid_in));
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   function automatic logic [5:0] atten(input logic [5:0] g, input logic dac_only);
      logic [1:0] a;
      a = g > 6'd27 ? 2'h2 : {1'b0, g > 6'd15};
      return dac_only ? {2'h0, g[3:0]} : {a, g - 6'd12 * a > 6'd15 ? 4'hf : 4'(g - 6'd12 * a)};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask
   // Strobe for one edge, then two idle edges so outputs settle
   task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic we);
      reg_address_in = a;
      reg_wdata_in = d;
      reg_write_in = we;
      reg_read_in = !we;
      tick(1);
      reg_write_in = 1'b0;
      reg_read_in = 1'b0;
      tick(2);
   endtask
   task automatic test_done();
      $display("mismatches %0d checks %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #40000;
      fail_count++;
      test_done();
   end
   initial begin
      tick(3);
      resetn_in = 1'b1;
      for (int i = 0; i < 8; i++) begin
         bus(ra[i], 8'h00, 1'b0);
         check(reg_rdata_out, i == 4 ? 8'h44 : (i == 5 ? 8'h43 : 8'h00));
      end
      for (int i = 0; i < 16; i++) begin
         c = i < 7 ? gc[i] : 6'(rnd());
         parallel_gain_port_in = 6'(rnd());
         bus(8'h0e, {7'h00, i[0]}, 1'b1);
         bus(8'h0b, {1'b0, i > 11, 6'h00}, 1'b1);
         bus(8'h0a, {2'h1, c}, 1'b1);
         bus(8'h0a, {2'h0, ~c}, 1'b1);
         if (i > 11) c = parallel_gain_port_in;
         check(tx_atten_out, atten(c, i[0]));
         check(current_amplifier_enable_out, !i[0]);
      end
      for (int i = 0; i < 8; i++) begin
         {p, s1, s2, s3} = {3'(rnd() % 5), 3'(rnd() % 5), 3'(rnd() % 7), 3'(rnd() % 6)};
         v = i == 0 ? 8'h44 : {i[0], s1, 1'b0, p};
         bus(8'h10, v, 1'b1);
         bus(8'h11, {1'b0, s2, 1'b0, s3}, 1'b1);
         check(gain_map_valid_out, v == 8'h44);
         if (!v[7]) {p, s1, s2, s3} = 12'h923;
         check(mirror_gain_out, {p, s1, s2, s3});
         check(secondary_gain_quarters_out, s1 * s2 * s3);
         bus(8'h12, 8'(rnd()) & 8'h77, 1'b1);
         check({secondary_offset_current_out, primary_offset_current_out},
            {reg_wdata_in[6:4], reg_wdata_in[2:0]});
      end
      // Negative impulse: an unsigned reading would lose the peak
      for (int f = 0; f < 3; f++) begin
         bus(8'h0c, {2'(f), 6'h00}, 1'b1);
         tick(150);
         baseband_feeder_i.send(10'h233);
         baseband_feeder_i.idle();
         pv = 0;
         for (int j = 0; j < 160; j++) begin
            n = signed'(tx_converter_data_out);
            if (-n > pv) begin
               pv = -n;
               pk = j;
               ps = tx_converter_data_out;
            end
            tick(1);
         end
         n = f == 0 ? 96 : (f == 1 ? 43 : 2);
         check(pk >= n - 6 && pk <= n + 6, 1'b1);
         if (f == 2) check(ps, 10'h233);
      end
      bus(8'h0c, 8'h00, 1'b1);
      for (int i = 0; i < 12; i++) baseband_feeder_i.send(10'(rnd()));
      baseband_feeder_i.idle();
      check(saw_full, 1'b1);
      tick(40);
      check(tx_ready_out, 1'b1);
      bus(8'h0c, 8'h40, 1'b1);
      half_duplex_pd_enable_in = 1'b1;
      tx_enable_in = 1'b0;
      for (n = 0; n < 200 && !tx_power_down_out; n++) tick(1);
      check(n >= 7 && n < 200, 1'b1);
      tx_enable_in = 1'b1;
      tick(2);
      check(tx_power_down_out, 1'b0);
      test_done();
   end
endmodule
